// ### core/tsr_readout.sv
`timescale 1ns/1ps
// Operation
// - A falling chip select aborts any conversion and loads the latest result into the shifter.
// - The word shifts out on falling serial clock edges, sign first, then the data MSB.
// - A read carries exactly one sixteen-bit frame.
// - The frame holds thirteen temperature bits on top and three trailing bits below.
// - Frame bit two is always driven low as a confirmation bit.
// - Frame bits one and zero leave the output in high impedance.
// - After power-up the serial output is in high impedance.
// - Temperature is two's complement at 0.0625 degrees per LSB.
// - Chip select held low idles the device with no conversion running.
// - While idle the latched result still shifts out on serial clock edges.
// - During power-on reset the interface is inactive and the result reads 0 degrees.
// - After power-on reset the device starts converting.
// - A chip select rise starts a new conversion and resets the interface.
module tsr_readout #(
  parameter logic [23:0] CONV_CYCLES = tsr_pkg::CONV_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic sck,
  output logic so_o,
  output logic so_oe,
  input wire logic [12:0] adc_sample,
  output logic converting,
  output logic [12:0] result
);
  // ****************************************
  // Pin sampling
  // ****************************************
  logic cs_lvl;
  logic cs_rise;
  logic cs_fall;
  logic sck_lvl;
  logic sck_rise;
  logic sck_fall;

  tsr_sync3 #(.RESET_VAL(1'b1)) u_cs (
    .mclk(mclk),
    .rst(rst),
    .pin(cs_n),
    .level(cs_lvl),
    .rise(cs_rise),
    .fall(cs_fall)
  );

  // Reset at the idle-high level of the clock pin so no false edge follows reset
  tsr_sync3 #(.RESET_VAL(1'b1)) u_sck (
    .mclk(mclk),
    .rst(rst),
    .pin(sck),
    .level(sck_lvl),
    .rise(sck_rise),
    .fall(sck_fall)
  );

  // ****************************************
  // Conversion engine
  // ****************************************
  // The analog front end is outside this block; a finished conversion
  // samples adc_sample once the conversion time has elapsed.
  tsr_pkg::tsr_conv_t conv_q;
  logic [23:0] conv_cnt_q;
  logic [12:0] result_q;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      conv_q <= tsr_pkg::TSR_CONVERT;
      conv_cnt_q <= 24'h000000;
    end else if (cs_fall) begin
      conv_q <= tsr_pkg::TSR_IDLE;
      conv_cnt_q <= 24'h000000;
    end else if (cs_rise) begin
      conv_q <= tsr_pkg::TSR_CONVERT;
      conv_cnt_q <= 24'h000000;
    end else begin
      case (conv_q)
        tsr_pkg::TSR_CONVERT: begin
          if (conv_cnt_q >= CONV_CYCLES - 24'h000001) begin
            conv_q <= tsr_pkg::TSR_DONE;
            conv_cnt_q <= 24'h000000;
          end else begin
            conv_cnt_q <= conv_cnt_q + 24'h000001;
          end
        end
        // Free-running: start the next conversion straight away
        tsr_pkg::TSR_DONE: conv_q <= tsr_pkg::TSR_CONVERT;
        tsr_pkg::TSR_IDLE: conv_q <= tsr_pkg::TSR_IDLE;
        default: conv_q <= tsr_pkg::TSR_CONVERT;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      result_q <= tsr_pkg::POR_TEMP;
    end else if (conv_q == tsr_pkg::TSR_CONVERT && !cs_fall && !cs_rise &&
                 conv_cnt_q >= CONV_CYCLES - 24'h000001) begin
      result_q <= adc_sample;
    end
  end

  assign converting = (conv_q == tsr_pkg::TSR_CONVERT);
  assign result = result_q;

  // ****************************************
  // Output shifter
  // ****************************************
  // An aborted conversion leaves the previous result in place, so a
  // shortened conversion never reaches the shifter.
  logic [15:0] shift_q;
  logic [4:0] bit_q;
  logic active_q;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      shift_q <= 16'h0000;
      bit_q <= 5'h00;
      active_q <= 1'b0;
    end else if (cs_fall) begin
      shift_q <= {result_q, tsr_pkg::CONFIRM_BIT, 2'b00};
      bit_q <= 5'h00;
      active_q <= 1'b1;
    end else if (cs_rise || cs_lvl) begin
      bit_q <= 5'h00;
      active_q <= 1'b0;
    end else if (active_q && sck_fall && bit_q < tsr_pkg::FRAME_LEN) begin
      shift_q <= {shift_q[14:0], 1'b0};
      bit_q <= bit_q + 5'h01;
    end
  end

  // ****************************************
  // Pin drive
  // ****************************************
  // Bit index 0 is the sign on the pin as soon as the frame opens; the
  // drive drops after D2 and stays off past the sixteenth bit.
  logic so_q;
  logic so_oe_q;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      so_q <= 1'b0;
      so_oe_q <= 1'b0;
    end else begin
      so_q <= (cs_fall) ? result_q[12] : shift_q[15];
      if (cs_fall) begin
        so_oe_q <= 1'b1;
      end else if (!active_q || cs_rise || cs_lvl) begin
        so_oe_q <= 1'b0;
      end else if (sck_fall && bit_q >= tsr_pkg::FRAME_LEN - tsr_pkg::LAST_DRIVEN_IDX) begin
        so_oe_q <= 1'b0;
      end
    end
  end

  assign so_o = so_q;
  assign so_oe = so_oe_q;

  logic unused_ok;
  assign unused_ok = sck_lvl ^ sck_rise;
endmodule : tsr_readout

// ### shared/tsr_pkg.sv
package tsr_pkg;
  // ****************************************
  // Frame layout
  // ****************************************
  localparam int FRAME_BITS = 16;
  localparam int TEMP_BITS = 13;
  localparam logic [4:0] LAST_DRIVEN_IDX = 5'h03;
  localparam logic [4:0] FRAME_LEN = 5'h10;
  localparam logic [12:0] POR_TEMP = 13'h0000;
  localparam logic CONFIRM_BIT = 1'b0;
  // ****************************************
  // Conversion timing
  // ****************************************
  localparam int CLK_HZ = 25000000;
  localparam int CONV_TIME_MS = 300;
  localparam longint CONV_CYCLES_L = (longint'(CONV_TIME_MS) * CLK_HZ) / 1000;
  localparam logic [23:0] CONV_CYCLES = CONV_CYCLES_L[23:0];
  typedef enum logic [1:0] {TSR_CONVERT, TSR_DONE, TSR_IDLE} tsr_conv_t;
endpackage : tsr_pkg

// ### core/tsr_sync3.sv
`timescale 1ns/1ps
// ****************************************
// Three-stage pin sampler; a change is accepted once stages two and three agree
// ****************************************
module tsr_sync3 #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic lvl_q;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s1_q <= RESET_VAL;
      s2_q <= RESET_VAL;
      s3_q <= RESET_VAL;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lvl_q <= RESET_VAL;
    end else if (s2_q == s3_q) begin
      lvl_q <= s3_q;
    end
  end

  assign level = lvl_q;
  assign rise = (s2_q == s3_q) && s3_q && !lvl_q;
  assign fall = (s2_q == s3_q) && !s3_q && lvl_q;
endmodule : tsr_sync3

// ### bench/tsr_readout_properties.sv
`timescale 1ns/1ps
// ****************************************
// Port checks for the readout
// ****************************************
module tsr_readout_chk (
  input wire logic mclk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic so_o,
  input wire logic so_oe,
  input wire logic [12:0] adc_sample,
  input wire logic converting,
  input wire logic [12:0] result
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  property p_por; $fell(rst) |-> !so_oe && result == 13'h0000; endproperty
  a_por: assert property (p_por) else $error("not clear after reset");
  property p_off; cs_n [*8] |-> !so_oe; endproperty
  a_off: assert property (p_off) else $error("driving while deselected");
  property p_idle; !cs_n [*8] |-> !converting; endproperty
  a_idle: assert property (p_idle) else $error("converting while selected");
  property p_sign; $rose(so_oe) |-> so_o == result[12]; endproperty
  a_sign: assert property (p_sign) else $error("first bit not the sign");
  // The bit shown just before release is the confirmation bit
  property p_conf; $fell(so_oe) && !cs_n |-> $past(so_o) == 1'b0; endproperty
  a_conf: assert property (p_conf) else $error("confirmation bit high");
  property p_tail; $fell(so_oe) && !cs_n |=> !so_oe [*8]; endproperty
  a_tail: assert property (p_tail) else $error("driven in trailing bits");
  property p_hold; (sck && !cs_n) [*8] |=> $stable(so_o); endproperty
  a_hold: assert property (p_hold) else $error("data moved without clock fall");
  property p_res; $changed(result) |-> result == $past(adc_sample); endproperty
  a_res: assert property (p_res) else $error("result not from sample");
  c_frame: cover property ($rose(so_oe));
  c_tail: cover property ($fell(so_oe) && !cs_n);
  c_res: cover property ($changed(result));
endmodule : tsr_readout_chk
bind tsr_readout tsr_readout_chk u_chk (.mclk(mclk), .rst(rst), .cs_n(cs_n), .sck(sck),
  .so_o(so_o), .so_oe(so_oe), .adc_sample(adc_sample), .converting(converting),
  .result(result));

// ### bench/tsr_master.sv
`timescale 1ns/1ps
// ****************************************
// Serial master, samples data on each clock fall
// ****************************************
module tsr_master (
  input wire logic mclk,
  output logic cs_n,
  output logic sck,
  input wire logic so_o,
  input wire logic so_oe
);
  initial begin
    cs_n = 1'b1;
    sck = 1'b1;
  end
  // Clock stands high outside frames; nb below 16 cuts a frame short on purpose
  task automatic read(input int pre, input int gap, input int nb, output logic [15:0] w,
    output logic [15:0] m);
    w = 16'h0000;
    m = 16'h0000;
    repeat (pre) @(posedge mclk);
    cs_n <= 1'b0;
    repeat (gap) @(posedge mclk);
    for (int i = 15; i > 15 - nb; i--) begin
      sck <= 1'b0;
      w[i] = so_o;
      m[i] = so_oe;
      repeat (4) @(posedge mclk);
      sck <= 1'b1;
      repeat (4) @(posedge mclk);
    end
    cs_n <= 1'b1;
  endtask : read
endmodule : tsr_master

// ### bench/tsr_readout_tb_top.sv
`timescale 1ns/1ps
// ****************************************
// Readout bench
// ****************************************
module tsr_readout_tb_top;
  logic mclk;
  logic rst;
  logic cs_n;
  logic sck;
  logic so_o;
  logic so_oe;
  logic converting;
  logic [12:0] adc_sample;
  logic [12:0] result;
  logic [12:0] t;
  logic [15:0] w;
  logic [15:0] m;
  // 0.0625, -0.0625, 25, 150 and -55 degrees
  logic [12:0] tv [5] = '{13'h0001, 13'h1fff, 13'h0190, 13'h0960, 13'h1c90};
  int seed = 37717;
  int num_errors = 0;
  int num_checks = 0;
  // Short conversion keeps the run brief; master waits 60 cycles between reads
  tsr_readout #(.CONV_CYCLES(24'h000032)) u_dut (.mclk(mclk), .rst(rst), .cs_n(cs_n),
    .sck(sck), .so_o(so_o), .so_oe(so_oe), .adc_sample(adc_sample),
    .converting(converting), .result(result));
  tsr_master u_mst (.mclk(mclk), .cs_n(cs_n), .sck(sck), .so_o(so_o), .so_oe(so_oe));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  function automatic logic [15:0] frame(input logic [12:0] v);
    return {v, tsr_pkg::CONFIRM_BIT, 2'b00};
  endfunction : frame
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim
  // Trailing two bits are undefined on the wire, so they are masked off
  task automatic rd(input int pre, input int gap, input logic [12:0] v);
    u_mst.read(pre, gap, 16, w, m);
    chk(w & 16'hfffc, frame(v));
    chk(m, 16'hfffc);
  endtask : rd
  initial begin
    rst = 1'b1;
    adc_sample = 13'h0abc;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rd(1, 8, tsr_pkg::POR_TEMP);
    for (int i = 0; i < 8; i++) begin
      if (i == 2) u_mst.read(60, 8, 5, w, m);
      t = (i < 5) ? tv[i] : 13'($random(seed));
      adc_sample <= t;
      rd(60, (i == 3) ? 100 : 8, t);
    end
    end_sim();
  end
  initial begin
    #200000;
    num_errors++;
    end_sim();
  end
endmodule : tsr_readout_tb_top
